// File: core/fppg_params.svh
// layout and constants shared by both ends of the port parity block
`ifndef FPPG_PARAMS_SVH
`define FPPG_PARAMS_SVH

`define FPPG_DATA_W 36
`define FPPG_LANES 4
`define FPPG_LANE_W 9
`define FPPG_PAR_BIT 8
`define FPPG_LANE_DATA_W 8
`define FPPG_PORTS 2
`define FPPG_WORD_RST 36'h0_0000_0000
`define FPPG_MASK_36 4'hF
`define FPPG_MASK_18 4'h3
`define FPPG_MASK_9 4'h1

`endif

// File: core/fppg_pkg.sv
// types and parity helpers of the port parity block
`include "fppg_params.svh"

package fppg_pkg;

  // bus width selected by bus matching on a port
  typedef enum logic [1:0] {
    FPPG_BW_36 = 2'h0,
    FPPG_BW_18 = 2'h1,
    FPPG_BW_9  = 2'h2
  } fppg_bw_t;

  // active byte lanes for a bus width; unknown codes fall back to full width
  function automatic logic [`FPPG_LANES-1:0] fppg_lane_mask(input fppg_bw_t bw);
    logic [`FPPG_LANES-1:0] m;
    m = `FPPG_MASK_36;
    if (bw == FPPG_BW_18) begin
      m = `FPPG_MASK_18;
    end else if (bw == FPPG_BW_9) begin
      m = `FPPG_MASK_9;
    end
    return m;
  endfunction

  // parity bit for eight data bits; odd mode makes the nine-bit group odd
  function automatic logic fppg_par_bit(input logic [`FPPG_LANE_DATA_W-1:0] d,
                                        input logic odd);
    return (^d) ^ odd;
  endfunction

endpackage

// File: core/fppg_if.sv
// one port of the fifo: glue logic on one side, the device on the other
`timescale 1ns/1ps
`default_nettype none
`include "fppg_params.svh"

interface fppg_if;
  logic [`FPPG_DATA_W-1:0] data_to_dev;   // write data toward the device
  logic [`FPPG_DATA_W-1:0] data_from_dev; // registered read data
  logic chip_select_n;                    // low selects the port
  logic enable;                           // access strobe, high
  logic write_read;                       // high write, low read
  logic mailbox_sel;                      // high targets the mailbox
  logic gen_request;                      // high asks for parity generation
  logic parity_err_n;                     // low while an active lane fails

  modport dev (
    input data_to_dev, chip_select_n, enable, write_read, mailbox_sel, gen_request,
    output data_from_dev, parity_err_n
  );

  modport host (
    output data_to_dev, chip_select_n, enable, write_read, mailbox_sel, gen_request,
    input data_from_dev, parity_err_n
  );
endinterface

`default_nettype wire

// File: core/fppg_dev.sv
// device end: parity trees, mailboxes and read output registers of both ports
//
// Notes on behaviour
// - either port can put parity in lane msbs
// - odd makes nine bits odd, even reverse
// - generate only with select low, request, enable
// - writes store all 36 input levels
// - tree uses lane low eight bits, mode input
// - requested: tree bit; otherwise stored msb passes
// - mailboxes share the port parity trees
// - mailbox read parity: read, mailbox, request
// - mailbox contents untouched by generation
// - four nine-bit trees per port
// - check spans nine bits, msb is parity
// - any failing active lane pulls error flag low
// - mode input low means even parity
// - only active lanes count toward the flag
// - checking never stalls or alters transfers
// - check on port inputs, before storage
// - glue withholds write strobe on error
// - glue writes normally without error
// - glue captures bad word, skips write
`timescale 1ns/1ps
`default_nettype none
`include "fppg_params.svh"

module fppg_dev
  import fppg_pkg::*;
#(
  parameter int DATA_W = `FPPG_DATA_W
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  fppg_if.dev port_a,
  fppg_if.dev port_b,
  input wire logic i_odd_even,
  input wire fppg_bw_t i_a_bus_width,
  input wire fppg_bw_t i_b_bus_width,
  input wire logic [DATA_W-1:0] i_a_fifo_rd_data,
  input wire logic [DATA_W-1:0] i_b_fifo_rd_data,
  output logic o_a_fifo_rd,
  output logic o_b_fifo_rd,
  output logic o_a_fifo_wr,
  output logic o_b_fifo_wr,
  output logic [DATA_W-1:0] o_a_fifo_wr_data,
  output logic [DATA_W-1:0] o_b_fifo_wr_data,
  output logic [DATA_W-1:0] o_mailbox_a_to_b,
  output logic [DATA_W-1:0] o_mailbox_b_to_a
);

  // both ports run the same logic, so every per-port signal is gathered into a
  // two-entry array here and one generate loop below builds the two copies
  // port 0 is port a, port 1 is port b; nets so each element has its own driver
  wire [DATA_W-1:0] din [`FPPG_PORTS];       // incoming port data
  wire [DATA_W-1:0] fifo_rdat [`FPPG_PORTS]; // word offered by the fifo core
  wire [`FPPG_LANES-1:0] lane_mask [`FPPG_PORTS]; // active lanes per port
  wire cs_n [`FPPG_PORTS];
  wire ena [`FPPG_PORTS];
  wire wr_sel [`FPPG_PORTS];
  wire mbx_sel [`FPPG_PORTS];
  wire gen_req [`FPPG_PORTS];
  // mailbox contents per port, read by the opposite port
  wire [DATA_W-1:0] mbx_q [`FPPG_PORTS];
  wire odd_sel;                              // one selects odd parity

  // gather both ports into arrays so one generate covers them
  assign din[0] = port_a.data_to_dev;
  assign din[1] = port_b.data_to_dev;
  assign fifo_rdat[0] = i_a_fifo_rd_data;
  assign fifo_rdat[1] = i_b_fifo_rd_data;
  assign lane_mask[0] = fppg_lane_mask(i_a_bus_width);
  assign lane_mask[1] = fppg_lane_mask(i_b_bus_width);
  assign cs_n[0] = port_a.chip_select_n;
  assign cs_n[1] = port_b.chip_select_n;
  assign ena[0] = port_a.enable;
  assign ena[1] = port_b.enable;
  assign wr_sel[0] = port_a.write_read;
  assign wr_sel[1] = port_b.write_read;
  assign mbx_sel[0] = port_a.mailbox_sel;
  assign mbx_sel[1] = port_b.mailbox_sel;
  assign gen_req[0] = port_a.gen_request;
  assign gen_req[1] = port_b.gen_request;

  // the mode input is shared: both ports check and generate alike, so a
  // change of mode takes effect on both ports at the same edge
  // a low mode input leaves the xor uninverted, i.e. even parity
  assign odd_sel = i_odd_even;

  // p walks the ports, l the byte lanes within a port
  genvar p;
  genvar l;
  generate
    for (p = 0; p < `FPPG_PORTS; p++) begin : g_port
      logic acc;                       // port selected and strobed
      logic wr_acc;                    // write taken this cycle
      logic rd_acc;                    // read taken this cycle
      logic gen_on;                    // generation asked on this read
      logic [DATA_W-1:0] rd_src;       // word chosen for the read
      logic [DATA_W-1:0] rd_word;      // read word after the trees
      logic [`FPPG_LANES-1:0] lane_err; // raw tree results on the inputs
      logic [DATA_W-1:0] mbx_ff;       // mailbox written by this port
      logic [DATA_W-1:0] nxt_mbx;
      logic [DATA_W-1:0] dout_ff;      // output register of the port
      logic [DATA_W-1:0] nxt_dout;
      logic [DATA_W-1:0] wdat_ff;      // word handed to the fifo core
      logic [DATA_W-1:0] nxt_wdat;
      logic wstb_ff;                   // fifo write strobe, one cycle
      logic nxt_wstb;
      logic perr_n;                    // combinational error flag

      // a write and a read cannot both be taken in one cycle on one port,
      // because write_read picks exactly one of them
      // access decode shared by read and write paths
      assign acc = ~cs_n[p] & ena[p];
      assign wr_acc = acc & wr_sel[p];
      assign rd_acc = acc & ~wr_sel[p];
      // mailbox reads need read select and request too, implied by rd_acc
      assign gen_on = rd_acc & gen_req[p];

      // cross wiring: port a reads what port b wrote and the reverse; a word
      // written and read in the same cycle shows the old contents here
      assign mbx_q[p] = mbx_ff;
      // the other port's mailbox feeds this port, through this port's trees
      assign rd_src = mbx_sel[p] ? mbx_q[`FPPG_PORTS-1-p] : fifo_rdat[p];

      // four trees, each owning one nine-bit lane
      for (l = 0; l < `FPPG_LANES; l++) begin : g_lane
        localparam int LO = l * `FPPG_LANE_W;
        // data bits pass untouched in every case
        assign rd_word[LO +: `FPPG_LANE_DATA_W] = rd_src[LO +: `FPPG_LANE_DATA_W];
        // msb: tree result when generating, else the stored msb
        assign rd_word[LO + `FPPG_PAR_BIT] = gen_on ?
            fppg_par_bit(rd_src[LO +: `FPPG_LANE_DATA_W], odd_sel) :
            rd_src[LO + `FPPG_PAR_BIT];
        // the check trees watch the pins even while the port is idle; glue
        // heeds the flag only on its own writes
        // check over all nine bits straight off the port inputs
        assign lane_err[l] = (^din[p][LO +: `FPPG_LANE_W]) ^ odd_sel;
      end

      // the flag is left combinational: registering it would arrive one edge
      // too late for glue that must hold back the write strobe of that word
      // unused lanes cannot pull the flag; high again once active lanes pass
      assign perr_n = ~|(lane_err & lane_mask[p]);

      // next state; checking feeds nothing here, so it never stalls a transfer
      always_comb begin
        nxt_mbx = mbx_ff;
        nxt_dout = dout_ff;
        nxt_wdat = wdat_ff;
        nxt_wstb = 1'b0;
        if (wr_acc) begin
          // raw levels stored, generation request plays no part
          if (mbx_sel[p]) begin
            nxt_mbx = din[p];
          end else begin
            nxt_wdat = din[p];
            nxt_wstb = 1'b1;
          end
        end else if (rd_acc) begin
          // only the output register changes, the mailbox keeps its word
          nxt_dout = rd_word;
        end
      end

      // reset clears every stored word; the flag has no state of its own
      // registers of the port
      always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          // a word in flight at reset is lost
          mbx_ff <= `FPPG_WORD_RST;
          dout_ff <= `FPPG_WORD_RST;
          wdat_ff <= `FPPG_WORD_RST;
          wstb_ff <= 1'b0;
        end else begin
          mbx_ff <= nxt_mbx;
          dout_ff <= nxt_dout;
          wdat_ff <= nxt_wdat;
          wstb_ff <= nxt_wstb;
        end
      end
    end
  endgenerate

  // the fifo read strobe is combinational so the core can present its word
  // in the same cycle that the output register loads it
  // port a outputs
  assign port_a.data_from_dev = g_port[0].dout_ff;
  assign port_a.parity_err_n = g_port[0].perr_n;
  assign o_a_fifo_rd = g_port[0].rd_acc & ~mbx_sel[0];
  assign o_a_fifo_wr = g_port[0].wstb_ff;
  assign o_a_fifo_wr_data = g_port[0].wdat_ff;
  // mailbox contents shown raw, never with generated parity
  assign o_mailbox_a_to_b = g_port[0].mbx_ff;

  // port b outputs
  assign port_b.data_from_dev = g_port[1].dout_ff;
  assign port_b.parity_err_n = g_port[1].perr_n;
  assign o_b_fifo_rd = g_port[1].rd_acc & ~mbx_sel[1];
  assign o_b_fifo_wr = g_port[1].wstb_ff;
  assign o_b_fifo_wr_data = g_port[1].wdat_ff;
  assign o_mailbox_b_to_a = g_port[1].mbx_ff;

endmodule

`default_nettype wire

// File: core/fppg_glue.sv
// glue end of one port: drives accesses and forces an exception on bad parity
`timescale 1ns/1ps
`default_nettype none
`include "fppg_params.svh"

module fppg_glue
  import fppg_pkg::*;
#(
  parameter int DATA_W = `FPPG_DATA_W
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  fppg_if.host bus,
  input wire logic i_wr_req,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic i_wr_mbx,
  input wire logic i_rd_req,
  input wire logic i_rd_mbx,
  input wire logic i_rd_gen,
  output logic o_wr_accept,
  output logic o_exception,
  output logic [DATA_W-1:0] o_err_word,
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data
);

  logic rd_take;                 // read goes out this cycle, writes win
  logic exc_ff;                  // one-cycle exception pulse
  logic nxt_exc;
  logic [DATA_W-1:0] errw_ff;    // last word refused for parity
  logic [DATA_W-1:0] nxt_errw;
  logic rd_pend_ff;              // device register loaded on the last edge; glue captures it on this edge
  logic nxt_rd_pend;
  logic rd_val_ff;
  logic nxt_rd_val;
  logic [DATA_W-1:0] rdat_ff;
  logic [DATA_W-1:0] nxt_rdat;

  assign rd_take = i_rd_req & ~i_wr_req;

  // access pins; the flag is combinational, so the gate acts in the same cycle
  assign bus.chip_select_n = ~(i_wr_req | i_rd_req);
  assign bus.write_read = i_wr_req;
  assign bus.mailbox_sel = i_wr_req ? i_wr_mbx : i_rd_mbx;
  assign bus.gen_request = rd_take & i_rd_gen;
  assign bus.data_to_dev = i_wr_data;
  // strobe withheld on a bad word, passed on a clean one
  assign bus.enable = i_wr_req ? bus.parity_err_n : i_rd_req;
  assign o_wr_accept = i_wr_req & bus.parity_err_n;

  // next values: exception capture and read return
  always_comb begin
    nxt_exc = 1'b0;
    nxt_errw = errw_ff;
    nxt_rd_pend = rd_take;
    nxt_rd_val = rd_pend_ff;
    nxt_rdat = rdat_ff;
    if (i_wr_req & ~bus.parity_err_n) begin
      // bad word kept for software, the cycle passes with no write
      nxt_exc = 1'b1;
      nxt_errw = i_wr_data;
    end
    if (rd_pend_ff) begin
      nxt_rdat = bus.data_from_dev;
    end
  end

  // registers of the glue
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      exc_ff <= 1'b0;
      errw_ff <= `FPPG_WORD_RST;
      rd_pend_ff <= 1'b0;
      rd_val_ff <= 1'b0;
      rdat_ff <= `FPPG_WORD_RST;
    end else begin
      exc_ff <= nxt_exc;
      errw_ff <= nxt_errw;
      rd_pend_ff <= nxt_rd_pend;
      rd_val_ff <= nxt_rd_val;
      rdat_ff <= nxt_rdat;
    end
  end

  assign o_exception = exc_ff;
  assign o_err_word = errw_ff;
  assign o_rd_valid = rd_val_ff;
  assign o_rd_data = rdat_ff;

endmodule

`default_nettype wire

// File: verif/fppg_asserts.sv
// assertions on the port a wires between the glue end and the device end
`timescale 1ns/1ps
`default_nettype none
`include "fppg_params.svh"

module fppg_asserts
  import fppg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_odd_even,
  input wire fppg_bw_t i_a_bus_width,
  input wire logic [35:0] i_data_to_dev,
  input wire logic [35:0] i_data_from_dev,
  input wire logic i_chip_select_n,
  input wire logic i_enable,
  input wire logic i_write_read,
  input wire logic i_mailbox_sel,
  input wire logic i_gen_request,
  input wire logic i_parity_err_n,
  input wire logic i_fifo_wr,
  input wire logic [35:0] i_fifo_wr_data,
  input wire logic [35:0] i_mailbox_a_to_b
);
  logic [3:0] lane_err; // per lane check result of the incoming word
  logic [3:0] lane_mask; // lanes that bus matching keeps active
  logic rd_take; // read taken at this edge
  logic wr_take; // write taken at this edge

  // worked out here, not from the package, so a shared slip cannot hide
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      lane_err[n] = ^i_data_to_dev[9*n +: 9] ^ i_odd_even;
    end
  end
  assign lane_mask = (i_a_bus_width == FPPG_BW_18) ? 4'h3 :
                     (i_a_bus_width == FPPG_BW_9) ? 4'h1 : 4'hF;
  assign rd_take = !i_chip_select_n && i_enable && !i_write_read;
  assign wr_take = !i_chip_select_n && i_enable && i_write_read;

  a_flag_any_lane: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_parity_err_n == !(|(lane_err & lane_mask))) else $error("error flag wrong");
  a_gen_low_lanes: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    rd_take && i_gen_request |=>
    i_data_from_dev[8] == (^i_data_from_dev[7:0] ^ $past(i_odd_even))
    && i_data_from_dev[17] == (^i_data_from_dev[16:9] ^ $past(i_odd_even)))
    else $error("low lanes not generated");
  a_gen_lane_two: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    rd_take && i_gen_request |=>
    i_data_from_dev[26] == (^i_data_from_dev[25:18] ^ $past(i_odd_even)))
    else $error("lane two not generated");
  a_gen_lane_three: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    rd_take && i_gen_request |=>
    i_data_from_dev[35] == (^i_data_from_dev[34:27] ^ $past(i_odd_even)))
    else $error("lane three not generated");
  a_read_holds: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !rd_take |=> $stable(i_data_from_dev)) else $error("read data moved without a read");
  a_write_gated: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    wr_take |-> i_parity_err_n) else $error("write strobed on a bad word");
  a_write_no_gen: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    wr_take |-> !i_gen_request) else $error("generate asked on a write");
  a_write_stored: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    wr_take |=> ($past(i_mailbox_sel) ? i_mailbox_a_to_b == $past(i_data_to_dev) :
    i_fifo_wr && i_fifo_wr_data == $past(i_data_to_dev))) else $error("write word not stored");
  a_err_blocks: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    !i_parity_err_n && i_write_read && !i_chip_select_n |-> !i_enable)
    else $error("bad word enabled");
endmodule

`default_nettype wire

// File: verif/tb.sv
// self-checking bench: both glue ends facing the device end
`timescale 1ns/1ps
`default_nettype none
`include "fppg_params.svh"

module tb
  import fppg_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_odd_even = 1'b0;
  fppg_bw_t bw [2] = '{FPPG_BW_36, FPPG_BW_36}; // bus width per port
  logic [35:0] fifo_q [2] = '{36'h0_0000_0000, 36'hF_FFFF_FFFF}; // fifo core words
  logic wr_req [2] = '{1'b0, 1'b0};
  logic [35:0] wr_data [2] = '{36'h0_0000_0000, 36'h0_0000_0000};
  logic wr_mbx [2] = '{1'b0, 1'b0};
  logic rd_req [2] = '{1'b0, 1'b0};
  logic rd_mbx [2] = '{1'b0, 1'b0};
  logic rd_gen [2] = '{1'b0, 1'b0};
  logic fifo_wr [2], fifo_rd [2], wr_acc [2], exc [2], rd_valid [2];
  logic [35:0] fifo_wd [2], err_word [2], rd_data [2];
  logic [35:0] mbx_ab, mbx_ba;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;

  fppg_if ifs [2] ();
  fppg_dev fppg_dev_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .port_a(ifs[0]),
    .port_b(ifs[1]), .i_odd_even(i_odd_even), .i_a_bus_width(bw[0]), .i_b_bus_width(bw[1]),
    .i_a_fifo_rd_data(fifo_q[0]), .i_b_fifo_rd_data(fifo_q[1]), .o_a_fifo_rd(fifo_rd[0]),
    .o_b_fifo_rd(fifo_rd[1]), .o_a_fifo_wr(fifo_wr[0]), .o_b_fifo_wr(fifo_wr[1]),
    .o_a_fifo_wr_data(fifo_wd[0]), .o_b_fifo_wr_data(fifo_wd[1]),
    .o_mailbox_a_to_b(mbx_ab), .o_mailbox_b_to_a(mbx_ba));
  // one glue end per port
  for (genvar p = 0; p < 2; p++) begin : g_port
    fppg_glue fppg_glue_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .bus(ifs[p]),
      .i_wr_req(wr_req[p]), .i_wr_data(wr_data[p]), .i_wr_mbx(wr_mbx[p]),
      .i_rd_req(rd_req[p]), .i_rd_mbx(rd_mbx[p]), .i_rd_gen(rd_gen[p]),
      .o_wr_accept(wr_acc[p]), .o_exception(exc[p]), .o_err_word(err_word[p]),
      .o_rd_valid(rd_valid[p]), .o_rd_data(rd_data[p]));
  end
  fppg_asserts fppg_asserts_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_odd_even(i_odd_even), .i_a_bus_width(bw[0]), .i_data_to_dev(ifs[0].data_to_dev),
    .i_data_from_dev(ifs[0].data_from_dev), .i_chip_select_n(ifs[0].chip_select_n),
    .i_enable(ifs[0].enable), .i_write_read(ifs[0].write_read),
    .i_mailbox_sel(ifs[0].mailbox_sel), .i_gen_request(ifs[0].gen_request),
    .i_parity_err_n(ifs[0].parity_err_n), .i_fifo_wr(fifo_wr[0]),
    .i_fifo_wr_data(fifo_wd[0]), .i_mailbox_a_to_b(mbx_ab));

  always #12.5 i_mclk = ~i_mclk;

  // word with every lane msb replaced by generated parity
  function automatic logic [35:0] gw(input logic [35:0] w, input logic odd);
    logic [35:0] r;
    r = w;
    for (int n = 0; n < 4; n++) r[9*n+8] = ^w[9*n +: 8] ^ odd;
    return r;
  endfunction

  task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one-cycle write request; acc sampled before the taking edge
  task automatic wr(input int p, input logic [35:0] d, input logic mb, output logic acc);
    @(posedge i_mclk);
    wr_req[p] <= 1'b1;
    wr_data[p] <= d;
    wr_mbx[p] <= mb;
    #1 acc = wr_acc[p];
    @(posedge i_mclk);
    wr_req[p] <= 1'b0;
    #1;
  endtask

  // one-cycle read request, bounded wait for the glue's valid pulse
  task automatic rd(input int p, input logic mb, input logic g, output logic [35:0] q);
    int n;
    @(posedge i_mclk);
    rd_req[p] <= 1'b1;
    rd_mbx[p] <= mb;
    rd_gen[p] <= g;
    #1 chk("fifo_rd", {35'h0, ~mb}, {35'h0, fifo_rd[p]});
    @(posedge i_mclk);
    rd_req[p] <= 1'b0;
    #1 n = 0;
    while (rd_valid[p] !== 1'b1 && n < 4) begin
      @(posedge i_mclk);
      #1 n++;
    end
    chk("rd_valid", 36'h1, {35'h0, rd_valid[p]});
    q = rd_data[p];
  endtask

  // mailbox a to b: stored as written, generation only on the read path
  task automatic t_mailbox();
    logic acc;
    logic [35:0] q, w;
    w = gw(36'h1_2345_6789, 1'b1);
    @(posedge i_mclk) i_odd_even <= 1'b1;
    wr(0, w, 1'b1, acc);
    chk("mbx_accept", 36'h1, {35'h0, acc});
    chk("mbx_ab", w, mbx_ab);
    @(posedge i_mclk) i_odd_even <= 1'b0;
    rd(1, 1'b1, 1'b1, q);
    chk("mbx_gen_even", gw(w, 1'b0), q);
    rd(1, 1'b1, 1'b0, q);
    chk("mbx_plain", w, q);
    chk("mbx_kept", w, mbx_ab);
    // mailbox b to a, read back on a with odd parity
    w = gw(36'h8_7654_3210, 1'b0);
    wr(1, w, 1'b1, acc);
    chk("mbx_ba_accept", 36'h1, {35'h0, acc});
    chk("mbx_ba", w, mbx_ba);
    @(posedge i_mclk) i_odd_even <= 1'b1;
    rd(0, 1'b1, 1'b1, q);
    chk("mbx_gen_odd", gw(w, 1'b1), q);
    chk("mbx_ba_kept", w, mbx_ba);
    @(posedge i_mclk) i_odd_even <= 1'b0;
  endtask

  // fifo writes on a and b, fifo reads on a (generated) and b (msbs passed)
  task automatic t_fifo();
    logic acc;
    logic [35:0] q, w;
    w = gw(36'hA_5A5A_5A5A, 1'b0);
    for (int p = 0; p < 2; p++) begin
      wr(p, w, 1'b0, acc);
      chk("fifo_accept", 36'h1, {35'h0, acc});
      chk("fifo_wr", 36'h1, {35'h0, fifo_wr[p]});
      chk("fifo_wd", w, fifo_wd[p]);
    end
    @(posedge i_mclk) fifo_q[0] <= 36'hF_0F0F_0F0F;
    rd(0, 1'b0, 1'b1, q);
    chk("fifo_gen", gw(36'hF_0F0F_0F0F, 1'b0), q);
    rd(1, 1'b0, 1'b0, q);
    chk("fifo_plain", 36'hF_FFFF_FFFF, q);
  endtask

  // bad word on a and b: refused, captured, no fifo write
  task automatic t_bad();
    logic acc;
    logic [35:0] w;
    w = gw(36'h0_00FF_00FF, 1'b0) ^ 36'h0_0000_0001;
    for (int p = 0; p < 2; p++) begin
      wr(p, w, 1'b0, acc);
      chk("bad_accept", 36'h0, {35'h0, acc});
      chk("bad_exc", 36'h1, {35'h0, exc[p]});
      chk("bad_no_wr", 36'h0, {35'h0, fifo_wr[p]});
      chk("bad_word", w, err_word[p]);
    end
  endtask

  // one bad lane at a time against every bus width
  task automatic t_width();
    for (int b = 0; b < 4; b++) begin
      for (int l = 0; l < 4; l++) begin
        @(posedge i_mclk);
        bw[0] <= fppg_bw_t'(b);
        wr_data[0] <= gw(36'h3_C3C3_C3C3, 1'b0) ^ (36'h0_0000_0001 << (9 * l));
        #1 chk("flag", (l < ((b == 1) ? 2 : (b == 2) ? 1 : 4)) ? 36'h0 : 36'h1,
          {35'h0, ifs[0].parity_err_n});
      end
    end
    @(posedge i_mclk) bw[0] <= FPPG_BW_36;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // hang guard, far above the roughly sixty cycles the run needs
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    repeat (5) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_mailbox();
    t_fifo();
    t_bad();
    t_width();
    close_out();
  end
endmodule

`default_nettype wire
